// File: tot_pkg.sv
package tot_pkg;

  // Clock and timing
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned BLINK_MS = 250;
  localparam int unsigned BLINK_CYCLES = (CLK_HZ / 1000) * BLINK_MS;
  localparam int unsigned BUSY_SETTLE_NS = 20;
  localparam int unsigned BUSY_SETTLE_CYCLES = (BUSY_SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  // Packet sizes in bytes and in 32-bit words
  localparam logic [31:0] PKT_BYTES_NORMAL = 32'd1460;
  localparam logic [31:0] PKT_BYTES_JUMBO = 32'd8960;
  localparam logic [15:0] PKT_WORDS_NORMAL = 16'd365;
  localparam logic [15:0] PKT_WORDS_JUMBO = 16'd2240;

  // Engine register addresses
  localparam logic [3:0] ENG_RST = 4'h0;
  localparam logic [3:0] ENG_CMD = 4'h1;
  localparam logic [3:0] ENG_MAC_LO = 4'h2;
  localparam logic [3:0] ENG_MAC_HI = 4'h3;
  localparam logic [3:0] ENG_LOCAL_IP = 4'h4;
  localparam logic [3:0] ENG_LOCAL_PORT = 4'h5;
  localparam logic [3:0] ENG_REMOTE_IP = 4'h6;
  localparam logic [3:0] ENG_TOTAL_LEN = 4'h7;
  localparam logic [3:0] ENG_PKT_LEN = 4'h8;
  localparam int unsigned ENG_BUSY_BIT = 0;

  // Engine parameter values
  localparam logic [31:0] LOCAL_MAC_LO = 32'h0203_0405;
  localparam logic [31:0] LOCAL_MAC_HI = 32'h0000_0001;
  localparam logic [31:0] LOCAL_IP = 32'hc0a8_0b2a;
  localparam logic [31:0] LOCAL_PORT = 32'h0000_0fa0;
  localparam logic [31:0] REMOTE_IP = 32'hc0a8_0b19;
  localparam logic [31:0] RST_RELEASE = 32'h0000_0000;
  localparam logic [31:0] CMD_SEND = 32'h0000_0000;
  localparam logic [31:0] CMD_CLOSE = 32'h0000_0003;
  localparam logic [2:0] PARAM_COUNT = 3'h5;

  // Avalon register offsets and reset values
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_TOTAL_LEN = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_RX_ERRORS = 4'hc;
  localparam int unsigned CTRL_START_BIT = 0;
  localparam int unsigned CTRL_CLR_ERR_BIT = 1;
  localparam logic [31:0] TOTAL_LEN_RST = 32'h0010_0000;
  localparam logic [31:0] PATTERN_INIT = 32'h0000_0000;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_SET_PARAM = 4'b0001,
    ST_RELEASE_RST = 4'b0011,
    ST_WAIT_INIT = 4'b0010,
    ST_WAIT_OPEN = 4'b0110,
    ST_SET_TOTAL_LEN = 4'b0111,
    ST_SET_PKT_LEN = 4'b0101,
    ST_ISSUE_SEND = 4'b0100,
    ST_WAIT_XFER_DONE = 4'b1100,
    ST_ACTIVE_CLOSE = 4'b1101,
    ST_WAIT_CLOSE_DONE = 4'b1111,
    ST_WAIT_CLOSE = 4'b1110
  } tot_state_t;

endpackage : tot_pkg

// File: tot_tx_gen.sv
`timescale 1ns/1ps
`default_nettype none
module tot_tx_gen #(
  parameter int DATA_W = 32
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic restart,
  input wire logic run,
  input wire logic jumbo,
  input wire logic [29:0] totalWords,
  input wire logic txFifoFull,
  output logic txFifoWrEn,
  output logic [DATA_W-1:0] txFifoWrData
);

  logic [15:0] pktWordCnt_r;
  logic [29:0] remaining_r;
  logic [15:0] pktWords;
  logic doWrite;

  assign pktWords = jumbo ? tot_pkg::PKT_WORDS_JUMBO : tot_pkg::PKT_WORDS_NORMAL;
  // Every other cycle so a full flag raised by our last write is seen
  assign doWrite = run && !txFifoFull && (remaining_r != 30'h0) && !txFifoWrEn;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      txFifoWrEn <= 1'b0;
    end else begin
      txFifoWrEn <= doWrite;
    end
  end

  // Word budget for the connection
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      remaining_r <= 30'h0;
    end else if (restart) begin
      remaining_r <= totalWords;
    end else if (doWrite) begin
      remaining_r <= remaining_r - 30'h1;
    end
  end

  // Pattern steps once per packet
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pktWordCnt_r <= 16'h0;
      txFifoWrData <= DATA_W'(tot_pkg::PATTERN_INIT);
    end else if (restart) begin
      pktWordCnt_r <= 16'h0;
      txFifoWrData <= DATA_W'(tot_pkg::PATTERN_INIT);
    end else if (txFifoWrEn) begin
      if (pktWordCnt_r == pktWords - 16'h1) begin
        pktWordCnt_r <= 16'h0;
        txFifoWrData <= txFifoWrData + DATA_W'(1);
      end else begin
        pktWordCnt_r <= pktWordCnt_r + 16'h1;
      end
    end
  end

endmodule : tot_tx_gen
`default_nettype wire

// File: tot_rx_chk.sv
`timescale 1ns/1ps
`default_nettype none
module tot_rx_chk #(
  parameter int DATA_W = 32
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic restart,
  input wire logic rxFifoEmpty,
  input wire logic [DATA_W-1:0] rxFifoRdData,
  output logic rxFifoRdEn,
  output logic mismatch,
  output logic [31:0] errorCount
);

  logic [DATA_W-1:0] expected_r;
  logic dataValid_r;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rxFifoRdEn <= 1'b0;
      dataValid_r <= 1'b0;
    end else begin
      rxFifoRdEn <= !rxFifoEmpty && !rxFifoRdEn;
      dataValid_r <= rxFifoRdEn;
    end
  end

  // Expected pattern steps per word
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      expected_r <= DATA_W'(tot_pkg::PATTERN_INIT);
    end else if (restart) begin
      expected_r <= DATA_W'(tot_pkg::PATTERN_INIT);
    end else if (dataValid_r) begin
      expected_r <= expected_r + DATA_W'(1);
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      mismatch <= 1'b0;
      errorCount <= 32'h0;
    end else begin
      mismatch <= dataValid_r && (rxFifoRdData != expected_r);
      if (dataValid_r && (rxFifoRdData != expected_r) && (errorCount != 32'hffff_ffff)) begin
        errorCount <= errorCount + 32'h1;
      end
    end
  end

endmodule : tot_rx_chk
`default_nettype wire

// File: tot_test_ctrl.sv
// The implementer's own choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module tot_test_ctrl #(
  parameter int DATA_W = 32,
  parameter int unsigned BLINK_CYCLES = tot_pkg::BLINK_CYCLES
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [3:0] avAddress,
  input wire logic avRead,
  input wire logic avWrite,
  input wire logic [31:0] avWritedata,
  input wire logic [3:0] avByteenable,
  output logic [31:0] avReaddata,
  output logic avWaitrequest,
  input wire logic packetSizeSwitch,
  input wire logic directionSwitch,
  input wire logic goButton,
  output logic errorIndicator,
  output logic [3:0] engRegAddr,
  output logic [31:0] engRegWrData,
  output logic engRegWrEn,
  input wire logic [31:0] engRegRdData,
  input wire logic connectionUp,
  output logic txFifoWrEn,
  output logic [DATA_W-1:0] txFifoWrData,
  input wire logic txFifoFull,
  input wire logic rxFifoEmpty,
  input wire logic [DATA_W-1:0] rxFifoRdData,
  output logic rxFifoRdEn
);

  tot_pkg::tot_state_t state_r;
  logic [2:0] paramIdx_r;
  logic [7:0] settle_r;
  logic txMode_r;
  logic goPrev_r;
  logic connPrev_r;
  logic [31:0] totalLen_r;
  logic startReq_r;
  logic errClrReq_r;
  logic errSticky_r;
  logic [31:0] blinkCnt_r;
  logic blinkTick_r;
  logic rxMismatch;
  logic [31:0] rxErrors;
  logic goPress;
  logic connRise;
  logic connFall;
  logic busAccept;
  logic settled;
  logic engBusy;
  logic txRun;
  logic engWr;
  logic [3:0] engAddr;
  logic [31:0] engData;

  assign goPress = (goButton && !goPrev_r) || startReq_r;
  assign connRise = connectionUp && !connPrev_r;
  assign connFall = !connectionUp && connPrev_r;
  assign busAccept = (avRead || avWrite) && !avWaitrequest;
  assign settled = (settle_r == 8'h0);
  assign engBusy = engRegRdData[tot_pkg::ENG_BUSY_BIT];
  assign txRun = txMode_r && connectionUp;

  // Edge detectors
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      goPrev_r <= 1'b0;
      connPrev_r <= 1'b0;
    end else begin
      goPrev_r <= goButton;
      connPrev_r <= connectionUp;
    end
  end

  // Avalon slave handshake: one wait cycle, then accept
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      avWaitrequest <= 1'b1;
    end else if ((avRead || avWrite) && avWaitrequest) begin
      avWaitrequest <= 1'b0;
    end else begin
      avWaitrequest <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      avReaddata <= 32'h0;
    end else if (avRead && avWaitrequest) begin
      case (avAddress)
        tot_pkg::REG_CTRL: avReaddata <= 32'h0;
        tot_pkg::REG_TOTAL_LEN: avReaddata <= totalLen_r;
        tot_pkg::REG_STATUS: avReaddata <= {24'h0, errSticky_r, engBusy, connectionUp,
                                            txMode_r, state_r};
        tot_pkg::REG_RX_ERRORS: avReaddata <= rxErrors;
        default: avReaddata <= 32'h0;
      endcase
    end
  end

  // Software registers
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      totalLen_r <= tot_pkg::TOTAL_LEN_RST;
    end else if (avWrite && !avWaitrequest && avAddress == tot_pkg::REG_TOTAL_LEN) begin
      for (int b = 0; b < 4; b++) begin
        if (avByteenable[b]) begin
          totalLen_r[b*8 +: 8] <= avWritedata[b*8 +: 8];
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      startReq_r <= 1'b0;
      errClrReq_r <= 1'b0;
    end else begin
      startReq_r <= 1'b0;
      errClrReq_r <= 1'b0;
      if (busAccept && avWrite && avAddress == tot_pkg::REG_CTRL && avByteenable[0]) begin
        startReq_r <= avWritedata[tot_pkg::CTRL_START_BIT];
        errClrReq_r <= avWritedata[tot_pkg::CTRL_CLR_ERR_BIT];
      end
    end
  end

  // Error flag and blink; a mismatch wins over a clear
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      errSticky_r <= 1'b0;
    end else if (rxMismatch) begin
      errSticky_r <= 1'b1;
    end else if (errClrReq_r) begin
      errSticky_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      blinkCnt_r <= 32'h0;
      blinkTick_r <= 1'b0;
    end else if (blinkCnt_r >= 32'(BLINK_CYCLES - 1)) begin
      blinkCnt_r <= 32'h0;
      blinkTick_r <= 1'b1;
    end else begin
      blinkCnt_r <= blinkCnt_r + 32'h1;
      blinkTick_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      errorIndicator <= 1'b0;
    end else if (!errSticky_r) begin
      errorIndicator <= 1'b0;
    end else if (blinkTick_r) begin
      errorIndicator <= !errorIndicator;
    end
  end

  // Direction latched at start
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      txMode_r <= 1'b0;
    end else if (state_r == tot_pkg::ST_IDLE && goPress) begin
      txMode_r <= directionSwitch;
    end
  end

  // Busy settle delay after each engine register write
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      settle_r <= 8'h0;
    end else if (engRegWrEn) begin
      settle_r <= 8'(tot_pkg::BUSY_SETTLE_CYCLES);
    end else if (!settled) begin
      settle_r <= settle_r - 8'h1;
    end
  end

  // Control sequence
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= tot_pkg::ST_IDLE;
      paramIdx_r <= 3'h0;
    end else begin
      case (state_r)
        tot_pkg::ST_IDLE: begin
          paramIdx_r <= 3'h0;
          if (goPress) begin
            state_r <= tot_pkg::ST_SET_PARAM;
          end
        end
        tot_pkg::ST_SET_PARAM: begin
          if (paramIdx_r == tot_pkg::PARAM_COUNT - 3'h1) begin
            state_r <= tot_pkg::ST_RELEASE_RST;
          end
          paramIdx_r <= paramIdx_r + 3'h1;
        end
        tot_pkg::ST_RELEASE_RST: state_r <= tot_pkg::ST_WAIT_INIT;
        tot_pkg::ST_WAIT_INIT: begin
          if (settled && !engWr && !engBusy) begin
            state_r <= tot_pkg::ST_WAIT_OPEN;
          end
        end
        tot_pkg::ST_WAIT_OPEN: begin
          if (connectionUp) begin
            state_r <= txMode_r ? tot_pkg::ST_SET_TOTAL_LEN
                                : tot_pkg::ST_WAIT_CLOSE;
          end
        end
        tot_pkg::ST_SET_TOTAL_LEN: state_r <= tot_pkg::ST_SET_PKT_LEN;
        tot_pkg::ST_SET_PKT_LEN: state_r <= tot_pkg::ST_ISSUE_SEND;
        tot_pkg::ST_ISSUE_SEND: state_r <= tot_pkg::ST_WAIT_XFER_DONE;
        tot_pkg::ST_WAIT_XFER_DONE: begin
          if (settled && !engWr && !engBusy) begin
            state_r <= tot_pkg::ST_ACTIVE_CLOSE;
          end
        end
        tot_pkg::ST_ACTIVE_CLOSE: state_r <= tot_pkg::ST_WAIT_CLOSE_DONE;
        tot_pkg::ST_WAIT_CLOSE_DONE: begin
          if (settled && !engWr && !engBusy) begin
            state_r <= tot_pkg::ST_WAIT_OPEN;
          end
        end
        tot_pkg::ST_WAIT_CLOSE: begin
          if (connFall) begin
            state_r <= tot_pkg::ST_WAIT_OPEN;
          end
        end
        default: state_r <= tot_pkg::ST_IDLE;
      endcase
    end
  end

  // Engine register port decoded from state
  always_comb begin
    engWr = 1'b0;
    engAddr = tot_pkg::ENG_CMD;
    engData = 32'h0;
    case (state_r)
      tot_pkg::ST_SET_PARAM: begin
        engWr = 1'b1;
        case (paramIdx_r)
          3'h0: begin
            engAddr = tot_pkg::ENG_MAC_LO;
            engData = tot_pkg::LOCAL_MAC_LO;
          end
          3'h1: begin
            engAddr = tot_pkg::ENG_MAC_HI;
            engData = tot_pkg::LOCAL_MAC_HI;
          end
          3'h2: begin
            engAddr = tot_pkg::ENG_LOCAL_IP;
            engData = tot_pkg::LOCAL_IP;
          end
          3'h3: begin
            engAddr = tot_pkg::ENG_LOCAL_PORT;
            engData = tot_pkg::LOCAL_PORT;
          end
          default: begin
            engAddr = tot_pkg::ENG_REMOTE_IP;
            engData = tot_pkg::REMOTE_IP;
          end
        endcase
      end
      tot_pkg::ST_RELEASE_RST: begin
        engWr = 1'b1;
        engAddr = tot_pkg::ENG_RST;
        engData = tot_pkg::RST_RELEASE;
      end
      tot_pkg::ST_SET_TOTAL_LEN: begin
        engWr = 1'b1;
        engAddr = tot_pkg::ENG_TOTAL_LEN;
        engData = totalLen_r;
      end
      tot_pkg::ST_SET_PKT_LEN: begin
        engWr = 1'b1;
        engAddr = tot_pkg::ENG_PKT_LEN;
        engData = packetSizeSwitch ? tot_pkg::PKT_BYTES_JUMBO : tot_pkg::PKT_BYTES_NORMAL;
      end
      tot_pkg::ST_ISSUE_SEND: begin
        engWr = 1'b1;
        engData = tot_pkg::CMD_SEND;
      end
      tot_pkg::ST_ACTIVE_CLOSE: begin
        engWr = 1'b1;
        engData = tot_pkg::CMD_CLOSE;
      end
      default: begin
        engWr = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      engRegWrEn <= 1'b0;
      engRegAddr <= tot_pkg::ENG_CMD;
      engRegWrData <= 32'h0;
    end else begin
      engRegWrEn <= engWr;
      engRegAddr <= engAddr;
      engRegWrData <= engData;
    end
  end

  tot_tx_gen #(
    .DATA_W(DATA_W)
  ) u_tx_gen (
    .core_clk(core_clk),
    .rstn(rstn),
    .restart(connRise),
    .run(txRun),
    .jumbo(packetSizeSwitch),
    .totalWords(totalLen_r[31:2]),
    .txFifoFull(txFifoFull),
    .txFifoWrEn(txFifoWrEn),
    .txFifoWrData(txFifoWrData)
  );

  tot_rx_chk #(
    .DATA_W(DATA_W)
  ) u_rx_chk (
    .core_clk(core_clk),
    .rstn(rstn),
    .restart(connRise),
    .rxFifoEmpty(rxFifoEmpty),
    .rxFifoRdData(rxFifoRdData),
    .rxFifoRdEn(rxFifoRdEn),
    .mismatch(rxMismatch),
    .errorCount(rxErrors)
  );

endmodule : tot_test_ctrl
`default_nettype wire

// File: tot_test_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none
module tot_test_ctrl_properties #(
  parameter int DATA_W = 32,
  parameter int unsigned BLINK_CYCLES = 8
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic packetSizeSwitch,
  input wire logic errorIndicator,
  input wire logic [3:0] engRegAddr,
  input wire logic [31:0] engRegWrData,
  input wire logic engRegWrEn,
  input wire logic [31:0] engRegRdData,
  input wire logic connectionUp,
  input wire logic txFifoWrEn,
  input wire logic [DATA_W-1:0] txFifoWrData,
  input wire logic txFifoFull,
  input wire logic rxFifoEmpty,
  input wire logic rxFifoRdEn
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  sequence wrS(logic [3:0] a, logic [31:0] d);
    engRegWrEn && engRegAddr == a && engRegWrData == d;
  endsequence
  sequence paramS;
    wrS(tot_pkg::ENG_MAC_HI, tot_pkg::LOCAL_MAC_HI) ##1
    wrS(tot_pkg::ENG_LOCAL_IP, tot_pkg::LOCAL_IP) ##1
    wrS(tot_pkg::ENG_LOCAL_PORT, tot_pkg::LOCAL_PORT) ##1
    wrS(tot_pkg::ENG_REMOTE_IP, tot_pkg::REMOTE_IP) ##1
    wrS(tot_pkg::ENG_RST, tot_pkg::RST_RELEASE);
  endsequence
  sequence sendS;
    engRegWrEn && engRegAddr == tot_pkg::ENG_PKT_LEN ##1 wrS(tot_pkg::ENG_CMD, tot_pkg::CMD_SEND);
  endsequence

  AST_PARAM_SEQ: assert property (
    engRegWrEn && engRegAddr == tot_pkg::ENG_MAC_LO
    |-> engRegWrData == tot_pkg::LOCAL_MAC_LO ##1 paramS)
    else $error("parameter writes out of order");
  AST_SEND_SEQ: assert property (
    engRegWrEn && engRegAddr == tot_pkg::ENG_TOTAL_LEN |=> sendS)
    else $error("send sequence broken");
  AST_PKT_LEN: assert property (
    engRegWrEn && engRegAddr == tot_pkg::ENG_PKT_LEN |-> engRegWrData ==
    (packetSizeSwitch ? tot_pkg::PKT_BYTES_JUMBO : tot_pkg::PKT_BYTES_NORMAL))
    else $error("wrong packet length");
  AST_CLOSE_IDLE: assert property (
    wrS(tot_pkg::ENG_CMD, tot_pkg::CMD_CLOSE)
    |-> $past(engRegAddr) == tot_pkg::ENG_CMD && !$past(engRegRdData[0]))
    else $error("close issued while busy");
  AST_ADDR_REST: assert property (
    !engRegWrEn |-> engRegAddr == tot_pkg::ENG_CMD)
    else $error("engine address not at rest");
  AST_RX_READ: assert property (
    rxFifoRdEn |-> !$past(rxFifoEmpty) ##1 !rxFifoRdEn)
    else $error("read from empty receive fifo");
  AST_TX_WRITE: assert property (
    txFifoWrEn |-> !$past(txFifoFull) && $past(connectionUp) ##1 !txFifoWrEn)
    else $error("transmit write not allowed");
  AST_TX_STEP: assert property (
    txFifoWrEn |-> txFifoWrData == $past(txFifoWrData)
    || txFifoWrData == $past(txFifoWrData) + 32'h1 || txFifoWrData == tot_pkg::PATTERN_INIT)
    else $error("transmit pattern jumped");
  // Hold of 8 matches the blink period used in simulation
  AST_BLINK: assert property (
    $rose(errorIndicator) |=> errorIndicator [*7])
    else $error("blink too short");
endmodule : tot_test_ctrl_properties

bind tot_test_ctrl tot_test_ctrl_properties #(.DATA_W(DATA_W), .BLINK_CYCLES(BLINK_CYCLES))
  u_tot_test_ctrl_properties (.core_clk, .rstn, .packetSizeSwitch, .errorIndicator,
  .engRegAddr, .engRegWrData, .engRegWrEn, .engRegRdData, .connectionUp, .txFifoWrEn,
  .txFifoWrData, .txFifoFull, .rxFifoEmpty, .rxFifoRdEn);
`default_nettype wire

// File: tot_eng_model.sv
`timescale 1ns/1ps
`default_nettype none
module tot_eng_model #(
  parameter int unsigned BUSY_LEN = 40
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [3:0] engRegAddr,
  input wire logic [31:0] engRegWrData,
  input wire logic engRegWrEn,
  output logic [31:0] engRegRdData,
  input wire logic connReq,
  output logic connectionUp,
  input wire logic txFifoWrEn,
  input wire logic txStall,
  output logic txFifoFull,
  input wire logic rxFifoRdEn,
  input wire logic rxLoad,
  input wire logic [31:0] rxWords,
  input wire logic [31:0] corruptIdx,
  output logic rxFifoEmpty,
  output logic [31:0] rxFifoRdData
);
  logic [7:0] busyCnt;
  logic closed;
  logic [31:0] rxLeft;
  logic [31:0] rxNext;
  // Busy only on the command address; others read all ones
  assign engRegRdData = (engRegAddr == tot_pkg::ENG_CMD) ? {31'h0, busyCnt != 8'h0} : 32'hffff_ffff;
  assign txFifoFull = txStall;
  assign rxFifoEmpty = (rxLeft == 32'h0);
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      busyCnt <= 8'h0;
    end else if (engRegWrEn && (engRegAddr == tot_pkg::ENG_RST || engRegAddr == tot_pkg::ENG_CMD)) begin
      busyCnt <= 8'(BUSY_LEN);
    end else if (txFifoWrEn) begin
      busyCnt <= 8'(BUSY_LEN);
    end else if (busyCnt != 8'h0) begin
      busyCnt <= busyCnt - 8'h1;
    end
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn || !connReq) begin
      connectionUp <= 1'b0;
      closed <= 1'b0;
    end else if (engRegWrEn && engRegAddr == tot_pkg::ENG_CMD && engRegWrData == tot_pkg::CMD_CLOSE) begin
      connectionUp <= 1'b0;
      closed <= 1'b1;
    end else if (!closed) begin
      connectionUp <= 1'b1;
    end
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rxLeft <= 32'h0;
      rxNext <= 32'h0;
      rxFifoRdData <= 32'h0;
    end else if (rxLoad) begin
      rxLeft <= rxWords;
      rxNext <= 32'h0;
    end else if (rxFifoRdEn && rxLeft != 32'h0) begin
      rxFifoRdData <= rxNext ^ {31'h0, rxNext == corruptIdx};
      rxNext <= rxNext + 32'h1;
      rxLeft <= rxLeft - 32'h1;
    end else begin
      rxFifoRdData <= ~rxFifoRdData;
    end
  end
endmodule : tot_eng_model
`default_nettype wire

// File: tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct packed {
    logic jumbo;
    logic [31:0] totalLen;
    logic [31:0] pktBytes;
  } tot_row_t;
  logic core_clk = 1'b0;
  logic rstn, avRead, avWrite, avWaitrequest, packetSizeSwitch, directionSwitch, goButton;
  logic errorIndicator, engRegWrEn, connectionUp, connReq, txFifoWrEn, txFifoFull, txStall;
  logic rxFifoEmpty, rxFifoRdEn, rxLoad;
  logic [3:0] avAddress, avByteenable, engRegAddr;
  logic [31:0] avWritedata, avReaddata, engRegWrData, engRegRdData, txFifoWrData;
  logic [31:0] rxFifoRdData, rxWords, corruptIdx, rdVal;
  logic [35:0] wrQ[$];
  int errCount, cmpCount, cyc, txCount, pktWords, k;
  tot_row_t rows[2];

  always #2.5 core_clk = ~core_clk;

  tot_test_ctrl #(.BLINK_CYCLES(8)) u_tot_test_ctrl (.core_clk, .rstn, .avAddress, .avRead,
    .avWrite, .avWritedata, .avByteenable, .avReaddata, .avWaitrequest, .packetSizeSwitch,
    .directionSwitch, .goButton, .errorIndicator, .engRegAddr, .engRegWrData, .engRegWrEn,
    .engRegRdData, .connectionUp, .txFifoWrEn, .txFifoWrData, .txFifoFull, .rxFifoEmpty,
    .rxFifoRdData, .rxFifoRdEn);
  tot_eng_model u_tot_eng_model (.core_clk, .rstn, .engRegAddr, .engRegWrData, .engRegWrEn,
    .engRegRdData, .connReq, .connectionUp, .txFifoWrEn, .txStall, .txFifoFull, .rxFifoRdEn,
    .rxLoad, .rxWords, .corruptIdx, .rxFifoEmpty, .rxFifoRdData);

  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      errCount++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task summarize;
    $display("Comparisons %0d mismatches %0d", cmpCount, errCount);
    if (errCount == 0 && cmpCount > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize

  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avAddress <= a;
    avWritedata <= d;
    avWrite <= wr;
    avRead <= !wr;
    do @(posedge core_clk); while (avWaitrequest !== 1'b0);
    rdVal = avReaddata;
    avWrite <= 1'b0;
    avRead <= 1'b0;
  endtask : bus

  task automatic waitState(input logic [3:0] s);
    int n;
    for (n = 0; n < 400; n++) begin
      bus(1'b0, tot_pkg::REG_STATUS, 32'h0);
      if (rdVal[3:0] === s) break;
    end
    check(rdVal[3:0], s);
  endtask : waitState

  task automatic waitWrites(input int n);
    int w;
    for (w = 0; w < 30000 && wrQ.size() < n; w++) @(posedge core_clk);
  endtask : waitWrites

  task automatic expectWr(input logic [3:0] a, input logic [31:0] d);
    check(wrQ.pop_front(), {a, d});
  endtask : expectWr

  always @(negedge core_clk) begin
    if (engRegWrEn === 1'b1) wrQ.push_back({engRegAddr, engRegWrData});
    if (txFifoWrEn === 1'b1) begin
      check(txFifoWrData, txCount / pktWords);
      txCount++;
    end
  end

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    txStall <= (cyc % 16) >= 12;
    if (cyc == 40000) begin
      errCount++;
      summarize();
    end
  end

  initial begin
    {rstn, avRead, avWrite, packetSizeSwitch, directionSwitch, goButton} = 6'h0;
    {connReq, txStall, rxLoad, avAddress, avWritedata, rxWords} = 71'h0;
    avByteenable = 4'hf;
    corruptIdx = 32'hffff_ffff;
    {errCount, cmpCount, cyc, txCount, pktWords} = {32'h0, 32'h0, 32'h0, 32'h0, 32'h1};
    rows[0] = '{1'b0, 32'd4380, tot_pkg::PKT_BYTES_NORMAL};
    rows[1] = '{1'b1, 32'd17920, tot_pkg::PKT_BYTES_JUMBO};
    repeat (20) @(posedge core_clk);
    rstn <= 1'b1;
    @(negedge core_clk);
    check({avWaitrequest, engRegWrEn, errorIndicator, txFifoWrEn, rxFifoRdEn}, 5'h10);
    check(engRegAddr, tot_pkg::ENG_CMD);
    bus(1'b0, tot_pkg::REG_TOTAL_LEN, 32'h0);
    check(rdVal, tot_pkg::TOTAL_LEN_RST);
    bus(1'b1, 4'h1, 32'h5555_aaaa);
    bus(1'b0, 4'h1, 32'h0);
    check(rdVal, 32'h0);
    waitState(tot_pkg::ST_IDLE);
    directionSwitch <= 1'b1;
    goButton <= 1'b1;
    repeat (3) @(posedge core_clk);
    goButton <= 1'b0;
    waitWrites(6);
    expectWr(tot_pkg::ENG_MAC_LO, tot_pkg::LOCAL_MAC_LO);
    expectWr(tot_pkg::ENG_MAC_HI, tot_pkg::LOCAL_MAC_HI);
    expectWr(tot_pkg::ENG_LOCAL_IP, tot_pkg::LOCAL_IP);
    expectWr(tot_pkg::ENG_LOCAL_PORT, tot_pkg::LOCAL_PORT);
    expectWr(tot_pkg::ENG_REMOTE_IP, tot_pkg::REMOTE_IP);
    expectWr(tot_pkg::ENG_RST, tot_pkg::RST_RELEASE);
    bus(1'b0, tot_pkg::REG_STATUS, 32'h0);
    check(rdVal[3:0], tot_pkg::ST_WAIT_INIT);
    waitState(tot_pkg::ST_WAIT_OPEN);
    foreach (rows[i]) begin
      bus(1'b1, tot_pkg::REG_TOTAL_LEN, rows[i].totalLen);
      packetSizeSwitch <= rows[i].jumbo;
      pktWords = rows[i].pktBytes / 4;
      txCount = 0;
      connReq <= 1'b1;
      waitWrites(4);
      waitState(tot_pkg::ST_WAIT_OPEN);
      expectWr(tot_pkg::ENG_TOTAL_LEN, rows[i].totalLen);
      expectWr(tot_pkg::ENG_PKT_LEN, rows[i].pktBytes);
      expectWr(tot_pkg::ENG_CMD, tot_pkg::CMD_SEND);
      expectWr(tot_pkg::ENG_CMD, tot_pkg::CMD_CLOSE);
      check(txCount, rows[i].totalLen / 4);
      connReq <= 1'b0;
    end
    rstn <= 1'b0;
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    waitState(tot_pkg::ST_IDLE);
    directionSwitch <= 1'b0;
    bus(1'b1, tot_pkg::REG_CTRL, 32'h1);
    waitState(tot_pkg::ST_WAIT_OPEN);
    for (int i = 0; i < 2; i++) begin
      connReq <= 1'b1;
      waitState(tot_pkg::ST_WAIT_CLOSE);
      corruptIdx <= (i == 1) ? 32'h5 : 32'hffff_ffff;
      rxWords <= 32'd40;
      rxLoad <= 1'b1;
      @(posedge core_clk);
      rxLoad <= 1'b0;
      @(negedge core_clk);
      for (k = 0; k < 500 && rxFifoEmpty !== 1'b1; k++) @(negedge core_clk);
      repeat (4) @(posedge core_clk);
      bus(1'b0, tot_pkg::REG_RX_ERRORS, 32'h0);
      check(rdVal, i);
      connReq <= 1'b0;
      waitState(tot_pkg::ST_WAIT_OPEN);
    end
    for (k = 0; k < 40 && errorIndicator !== 1'b1; k++) @(negedge core_clk);
    check(errorIndicator, 1'b1);
    for (k = 0; k < 40 && errorIndicator !== 1'b0; k++) @(negedge core_clk);
    bus(1'b1, tot_pkg::REG_CTRL, 32'h2);
    repeat (20) @(negedge core_clk);
    check(errorIndicator, 1'b0);
    summarize();
  end
endmodule : tb
`default_nettype wire
